// ---- verilog/lsfs_top.sv ----
//
// Overview of operation
// RULE1 - Enable input high disables switch and enters low power; low enables it.
// RULE2 - Wait 17 ms debounce after enable valid before switch on and ramp.
// RULE3 - Hold switch off during input undervoltage; otherwise follow enable and faults.
// RULE4 - Ramp output with controlled slew for nominally 3 ms after debounce.
// RULE5 - Apply 2 A soft-start current limit, release it after 7 ms.
// RULE6 - Wait 3 ms more, then flag power good if output near input.
// RULE7 - Input over-voltage trip turns switch off even when enabled; over-voltage fault.
// RULE8 - Grounded adjust input selects internal 23 V trip, else external divided trip.
// RULE9 - Reverse-current blocking always active; regulate droop when enabled.
// RULE10 - Restore full conduction 15 us after reverse condition ends, no restart.
// RULE11 - Reverse-current regulation is no fault; power good and retry unaffected.
// RULE12 - Over-current above 20 A turns switch off and records a fault.
// RULE13 - Output droop in normal operation flags a soft-short fault.
// RULE14 - Output failing to ramp in soft-start flags short, first start or retry.
// RULE15 - Over-temperature above 150 C opens switch; clears below 130 C.
// RULE16 - Every opening fault retries through full debounce and ramp when clear.
// RULE17 - Retry repeats on recurring faults until cleared, disabled or undervoltage.
// RULE18 - Power good pulled low only when switch on and no fault active.
// RULE19 - Host supplies pull-up on power good and reads low as good.
// RULE20 - Recovery from over-voltage, current or temperature waits debounce plus ramp.
// RULE21 - Begin turning off within 3 us after enable deasserted.
// RULE22 - Millisecond intervals from counters; fault or disable restarts from debounce.
// RULE23 - Comparator outputs and enable pass two flip-flops before sequencing.
//
`timescale 1ns/1ps
`default_nettype none
module lsfs_top #(
  parameter logic [17:0] DEB_CYC = lsfs_pkg::DEB_CYC,
  parameter logic [17:0] RAMP_CYC = lsfs_pkg::RAMP_CYC,
  parameter logic [17:0] SSLIM_CYC = lsfs_pkg::SSLIM_CYC,
  parameter logic [17:0] PGDLY_CYC = lsfs_pkg::PGDLY_CYC
) (
  input wire logic clock_in,
  input wire logic rst_in,
  // Wishbone classic slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Pins and comparator outputs, all asynchronous
  input wire logic enable_n_in,
  input wire logic input_undervoltage_lockout_in,
  input wire logic overvoltage_adjust_input_in,
  input wire logic int_ovp_trip_in,
  input wire logic ext_ovp_trip_in,
  input wire logic overcurrent_fault_in,
  input wire logic output_short_fault_in,
  input wire logic vout_near_vin_in,
  input wire logic temp_hot_in,
  input wire logic temp_cool_in,
  input wire logic reverse_current_in,
  // Switch control
  output logic switch_on_out,
  output logic ramp_active_out,
  output logic current_limit_out,
  output logic rcp_regulate_out,
  output logic low_power_out,
  output logic power_good_flag_n_out,
  output logic power_good_flag_n_oe_out
);

  localparam int toff_lim = lsfs_pkg::TOFF_CYC;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [10:0] raw_in;
  logic [10:0] syn;
  assign raw_in = {reverse_current_in, temp_cool_in, temp_hot_in,
                   vout_near_vin_in, output_short_fault_in,
                   overcurrent_fault_in, ext_ovp_trip_in, int_ovp_trip_in,
                   overvoltage_adjust_input_in,
                   input_undervoltage_lockout_in, enable_n_in};

  // Every pin crosses two flops before use
  lsfs_sync #(.WIDTH(11)) u_sync ( // RULE23
    .clock_in(clock_in),
    .rst_in(rst_in),
    .async_in(raw_in),
    .sync_out(syn)
  );

  wire en_n_s = syn[0];
  wire input_undervoltage_lockout_s = syn[1];
  wire adj_s = syn[2];
  wire int_ovp_s = syn[3];
  wire ext_ovp_s = syn[4];
  wire ocp_s = syn[5];
  wire short_s = syn[6];
  wire near_s = syn[7];
  wire hot_s = syn[8];
  wire cool_s = syn[9];
  wire rev_s = syn[10];

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  lsfs_pkg::lsfs_state_type state;
  lsfs_pkg::lsfs_state_type next_state;
  logic [17:0] cnt;
  logic sw_disable;
  logic otp_latched;
  logic [15:0] retry_cnt;
  logic [7:0] rcp_cnt;
  logic [lsfs_pkg::NFAULT-1:0] sticky;
  logic [1:0] sync_primed;

  // ----------------------------------------------------------------
  // Fault decode
  // ----------------------------------------------------------------
  // Grounded adjust pin selects the internal trip point
  wire ovp_trip = adj_s ? ext_ovp_s : int_ovp_s; // RULE8
  wire in_start = (state == lsfs_pkg::ST_SOFTSTART) ||
                  (state == lsfs_pkg::ST_PGWAIT);
  // Short during start, or output still low when limit window ends
  wire ramp_fail = (state == lsfs_pkg::ST_SOFTSTART) &&
                   (cnt == SSLIM_CYC - 18'h1) && !near_s; // RULE14
  wire pg_fail = (state == lsfs_pkg::ST_PGWAIT) &&
                 (cnt == PGDLY_CYC - 18'h1) && !near_s; // RULE14
  wire short_det = (short_s && (in_start || state == lsfs_pkg::ST_ON)) ||
                   ramp_fail || pg_fail; // RULE13 RULE14
  wire [lsfs_pkg::NFAULT-1:0] faults;
  assign faults[lsfs_pkg::F_OVP] = ovp_trip; // RULE7
  assign faults[lsfs_pkg::F_OCP] = ocp_s; // RULE12
  assign faults[lsfs_pkg::F_SHORT] = short_det;
  assign faults[lsfs_pkg::F_OTP] = otp_latched || hot_s; // RULE15
  // Reverse current is deliberately absent from the fault vector
  wire any_fault = |faults; // RULE11
  // Level-type faults still present block the retry
  wire fault_hold = ovp_trip || ocp_s || otp_latched || hot_s;
  wire disabled = en_n_s || input_undervoltage_lockout_s || sw_disable || !sync_primed[1]; // RULE1 RULE3 RULE23

  // Cleared synchroniser reads as enabled; hold off until both stages carry pin values
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sync_primed <= 2'h0;
    end else begin
      sync_primed <= {sync_primed[0], 1'b1}; // RULE23
    end
  end

  // Over-temperature hysteresis: set hot, clear only when cool
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      otp_latched <= 1'b0;
    end else if (hot_s) begin
      otp_latched <= 1'b1; // RULE15
    end else if (cool_s) begin
      otp_latched <= 1'b0; // RULE15
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Disable wins over everything; a fault restarts via debounce
  always_comb begin
    next_state = state;
    case (state)
      lsfs_pkg::ST_OFF: begin
        if (!disabled && !fault_hold) begin
          next_state = lsfs_pkg::ST_DEBOUNCE;
        end
      end
      lsfs_pkg::ST_DEBOUNCE: begin
        if (cnt == DEB_CYC - 18'h1) begin
          next_state = lsfs_pkg::ST_SOFTSTART; // RULE2
        end
      end
      lsfs_pkg::ST_SOFTSTART: begin
        if (cnt == SSLIM_CYC - 18'h1) begin
          next_state = lsfs_pkg::ST_PGWAIT; // RULE5
        end
      end
      lsfs_pkg::ST_PGWAIT: begin
        if (cnt == PGDLY_CYC - 18'h1) begin
          next_state = lsfs_pkg::ST_ON; // RULE6
        end
      end
      lsfs_pkg::ST_ON: begin
        next_state = lsfs_pkg::ST_ON;
      end
      lsfs_pkg::ST_FAULT: begin
        if (!fault_hold) begin
          next_state = lsfs_pkg::ST_DEBOUNCE; // RULE16 RULE20
        end
      end
      default: begin
        next_state = lsfs_pkg::ST_OFF;
      end
    endcase
    if (disabled) begin
      next_state = lsfs_pkg::ST_OFF; // RULE1 RULE3 RULE17
    end else if (any_fault && state != lsfs_pkg::ST_OFF) begin
      next_state = lsfs_pkg::ST_FAULT; // RULE17 RULE22
    end
  end

  // State and interval counter; counter restarts on every change
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state <= lsfs_pkg::ST_OFF;
      cnt <= 18'h0;
    end else begin
      state <= next_state;
      cnt <= (next_state != state) ? 18'h0 : cnt + 18'h1; // RULE22
    end
  end

  // Retry counter saturates so software can see a stuck fault
  always_ff @(posedge clock_in) begin
    if (rst_in || disabled) begin
      retry_cnt <= 16'h0;
    end else if (next_state == lsfs_pkg::ST_FAULT &&
                 state != lsfs_pkg::ST_FAULT && retry_cnt != 16'hffff) begin
      retry_cnt <= retry_cnt + 16'h1;
    end
  end

  // ----------------------------------------------------------------
  // Reverse-current regulation
  // ----------------------------------------------------------------
  // Regulate while reverse seen, hold 15 us after it ends
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rcp_cnt <= 8'h0;
    end else if (rev_s) begin
      rcp_cnt <= lsfs_pkg::RCPREC_CYC; // RULE10
    end else if (rcp_cnt != 8'h0) begin
      rcp_cnt <= rcp_cnt - 8'h1; // RULE10
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  wire next_on = (next_state == lsfs_pkg::ST_SOFTSTART) ||
                 (next_state == lsfs_pkg::ST_PGWAIT) ||
                 (next_state == lsfs_pkg::ST_ON);
  wire next_ramp = (next_state == lsfs_pkg::ST_SOFTSTART) &&
                   ((next_state != state) || (cnt < RAMP_CYC - 18'h1));
  // Reverse regulation only modulates gate while conducting
  wire next_rcp = next_on && (rev_s || rcp_cnt != 8'h0); // RULE9
  wire next_pg = (next_state == lsfs_pkg::ST_ON) && near_s &&
                 !any_fault && !input_undervoltage_lockout_s; // RULE6 RULE18 RULE11

  // Outputs registered from next-state, so off is one cycle after cause
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      switch_on_out <= 1'b0;
      ramp_active_out <= 1'b0;
      current_limit_out <= 1'b0;
      rcp_regulate_out <= 1'b0;
      low_power_out <= 1'b1;
      power_good_flag_n_oe_out <= 1'b0;
      power_good_flag_n_out <= 1'b0;
    end else begin
      switch_on_out <= next_on; // RULE3 RULE7 RULE12 RULE21
      ramp_active_out <= next_ramp; // RULE4
      current_limit_out <= next_state == lsfs_pkg::ST_SOFTSTART; // RULE5
      rcp_regulate_out <= next_rcp; // RULE9
      low_power_out <= next_state == lsfs_pkg::ST_OFF; // RULE1
      power_good_flag_n_oe_out <= next_pg; // RULE18
      power_good_flag_n_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  wire wb_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire ctrl_wr = wb_req && wb_we_in && wb_sel_in[0] &&
                 (wb_adr_in == lsfs_pkg::CTRL_ADDR);
  wire [31:0] status_word = {16'h0, sticky, 3'h0, power_good_flag_n_oe_out,
                             rcp_regulate_out, current_limit_out,
                             switch_on_out, 1'b0, 4'(state)};
  wire [31:0] rd_mux = (wb_adr_in == lsfs_pkg::CTRL_ADDR) ? {31'h0, sw_disable} :
                       (wb_adr_in == lsfs_pkg::STATUS_ADDR) ? status_word :
                       (wb_adr_in == lsfs_pkg::RETRY_ADDR) ? {16'h0, retry_cnt} :
                       32'h0;
  wire st_wr = wb_req && wb_we_in && wb_sel_in[1] &&
               (wb_adr_in == lsfs_pkg::STATUS_ADDR);
  wire [lsfs_pkg::NFAULT-1:0] clr_mask = st_wr ? wb_dat_in[11:8] : '0;

  // One-wait-state answer; unmapped reads zero, writes ignored
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0;
      sw_disable <= lsfs_pkg::CTRL_RESET;
    end else begin
      wb_ack_out <= wb_req;
      wb_dat_out <= (wb_req && !wb_we_in) ? rd_mux : 32'h0;
      if (ctrl_wr) begin
        sw_disable <= wb_dat_in[lsfs_pkg::CTRL_DIS_BIT];
      end
    end
  end

  // Sticky fault record; a new fault beats a clear in the same cycle
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sticky <= '0;
    end else begin
      sticky <= (sticky & ~clr_mask) | faults; // RULE12
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  chk_disable_off: assert property (en_n_s |-> ##[1:toff_lim] !switch_on_out) // RULE1 RULE21
    else $error("switch not off after disable");
  chk_input_undervoltage_lockout_off: assert property (input_undervoltage_lockout_s |=> !switch_on_out && low_power_out) // RULE3
    else $error("switch on during undervoltage");
  chk_ovp_off: assert property (ovp_trip && !disabled |=> !switch_on_out) // RULE7 RULE8
    else $error("switch on during overvoltage");
  chk_ocp_off: assert property (ocp_s |=> !switch_on_out ##0 sticky[lsfs_pkg::F_OCP]) // RULE12
    else $error("overcurrent not handled");
  chk_debounce_len: assert property (state == lsfs_pkg::ST_DEBOUNCE &&
      cnt < DEB_CYC - 18'h1 && !disabled && !any_fault |=> !switch_on_out) // RULE2 RULE16
    else $error("switch on during debounce");
  chk_start_order: assert property ($rose(switch_on_out) |-> ramp_active_out &&
      current_limit_out && $past(state) == lsfs_pkg::ST_DEBOUNCE) // RULE4 RULE5 RULE20
    else $error("start without debounce");
  chk_pg_cond: assert property (power_good_flag_n_oe_out |->
      switch_on_out && !current_limit_out && !$past(input_undervoltage_lockout_s)) // RULE18 RULE6
    else $error("power good while not on");
  chk_rcp_nofault: assert property (state == lsfs_pkg::ST_ON && rev_s &&
      !disabled && !any_fault |=> state == lsfs_pkg::ST_ON) // RULE11
    else $error("reverse current left on state");
  chk_rcp_recover: assert property ($fell(rev_s) && switch_on_out && !disabled &&
      !any_fault |-> ##[150:152] !rcp_regulate_out) // RULE10
    else $error("reverse recovery time wrong");
  chk_otp_hyst: assert property (otp_latched && !cool_s |=> otp_latched) // RULE15
    else $error("overtemp cleared early");

  cov_reach_on: cover property (state == lsfs_pkg::ST_ON && power_good_flag_n_oe_out);
  cov_retry: cover property (state == lsfs_pkg::ST_FAULT ##1 state == lsfs_pkg::ST_DEBOUNCE);
  cov_ramp_fail: cover property (ramp_fail);
  cov_rcp: cover property (rcp_regulate_out && state == lsfs_pkg::ST_ON);

endmodule : lsfs_top
`default_nettype wire

// ---- common/lsfs_pkg.sv ----
package lsfs_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int DEB_MS = 17;
  localparam int RAMP_MS = 3;
  localparam int SSLIM_MS = 7;
  localparam int PGDLY_MS = 3;
  localparam int RCPREC_US = 15;
  localparam int TOFF_US = 3;
  localparam logic [17:0] DEB_CYC = 18'(DEB_MS * (CLK_HZ / 1000));
  localparam logic [17:0] RAMP_CYC = 18'(RAMP_MS * (CLK_HZ / 1000));
  localparam logic [17:0] SSLIM_CYC = 18'(SSLIM_MS * (CLK_HZ / 1000));
  localparam logic [17:0] PGDLY_CYC = 18'(PGDLY_MS * (CLK_HZ / 1000));
  localparam logic [7:0] RCPREC_CYC = 8'(RCPREC_US * (CLK_HZ / 1_000_000));
  localparam int TOFF_CYC = TOFF_US * (CLK_HZ / 1_000_000);

  // ----------------------------------------------------------------
  // Register map (byte addresses, 32-bit words)
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam logic [3:0] RETRY_ADDR = 4'h8;
  localparam logic CTRL_RESET = 1'b0;
  localparam int CTRL_DIS_BIT = 0;

  // ----------------------------------------------------------------
  // Fault vector positions
  // ----------------------------------------------------------------
  localparam int F_OVP = 0;
  localparam int F_OCP = 1;
  localparam int F_SHORT = 2;
  localparam int F_OTP = 3;
  localparam int NFAULT = 4;

  typedef enum {
    ST_OFF,
    ST_DEBOUNCE,
    ST_SOFTSTART,
    ST_PGWAIT,
    ST_ON,
    ST_FAULT
  } lsfs_state_type;

endpackage : lsfs_pkg

// ---- verilog/lsfs_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module lsfs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------
  // Two-stage synchroniser; first stage feeds only the second
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] stage1;

  // Reset value is zero: comparator outputs read as inactive
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : lsfs_sync
`default_nettype wire

// ---- verif/lsfs_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Host side: drives enable, senses the power good flag
// ----------------------------------------------------------------
module lsfs_host_model (
  input wire logic clock_in,
  input wire logic run_in,
  input wire logic pg_n_in,
  input wire logic pg_oe_in,
  output logic enable_n_out,
  output logic pg_pin_out
);
  // Pull-up holds the released flag high, so only a driven low reads as good
  assign pg_pin_out = pg_oe_in ? pg_n_in : 1'b1;
  // Enable moves only after an edge; starts disabled so no glitch at power up
  initial enable_n_out = 1'b1;
  always @(posedge clock_in) begin
    enable_n_out <= ~run_in;
  end
endmodule : lsfs_host_model
`default_nettype wire

// ---- verif/lsfs_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module lsfs_tb_top;
  // ----------------------------------------------------------------
  // Shortened counts keep the run short
  // ----------------------------------------------------------------
  localparam logic [17:0] DEB = 18'h14;
  localparam logic [17:0] RMP = 18'h5;
  localparam logic [17:0] LIM = 18'ha;
  localparam logic [17:0] PGD = 18'h6;
  localparam int RCPR = lsfs_pkg::RCPREC_CYC;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
  logic [3:0] wb_adr_in = 4'h0, wb_sel_in = 4'h0;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out, rd;
  logic run = 1'b0, input_undervoltage_lockout = 1'b0, adj = 1'b0, near = 1'b1, cool = 1'b1, rev = 1'b0;
  logic [4:0] flt = 5'h00;
  logic wb_ack_out, enable_n, pg_pin, switch_on_out, ramp_active_out, current_limit_out;
  logic rcp_regulate_out, low_power_out, power_good_flag_n_out, power_good_flag_n_oe_out;
  int n_errors = 0;
  int num_checks = 0;
  int n;
  int sb[5] = '{lsfs_pkg::F_OVP, lsfs_pkg::F_OVP, lsfs_pkg::F_OCP, lsfs_pkg::F_SHORT,
                lsfs_pkg::F_OTP};

  // Free-running 10 MHz clock
  initial begin
    forever #50 clock_in = ~clock_in;
  end

  lsfs_top #(.DEB_CYC(DEB), .RAMP_CYC(RMP), .SSLIM_CYC(LIM), .PGDLY_CYC(PGD)) dut (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in),
    .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out),
    .enable_n_in(enable_n),
    .input_undervoltage_lockout_in(input_undervoltage_lockout),
    .overvoltage_adjust_input_in(adj),
    .int_ovp_trip_in(flt[0]),
    .ext_ovp_trip_in(flt[1]),
    .overcurrent_fault_in(flt[2]),
    .output_short_fault_in(flt[3]),
    .vout_near_vin_in(near),
    .temp_hot_in(flt[4]),
    .temp_cool_in(cool),
    .reverse_current_in(rev),
    .switch_on_out(switch_on_out),
    .ramp_active_out(ramp_active_out),
    .current_limit_out(current_limit_out),
    .rcp_regulate_out(rcp_regulate_out),
    .low_power_out(low_power_out),
    .power_good_flag_n_out(power_good_flag_n_out),
    .power_good_flag_n_oe_out(power_good_flag_n_oe_out)
  );

  lsfs_host_model host (
    .clock_in(clock_in),
    .run_in(run),
    .pg_n_in(power_good_flag_n_out),
    .pg_oe_in(power_good_flag_n_oe_out),
    .enable_n_out(enable_n),
    .pg_pin_out(pg_pin)
  );

  // ----------------------------------------------------------------
  // Report, compare and wait helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rng(input string what, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("FAIL %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : rng

  function automatic logic pick(input int s);
    case (s)
      0: return switch_on_out;
      1: return ramp_active_out;
      2: return current_limit_out;
      3: return rcp_regulate_out;
      default: return power_good_flag_n_oe_out;
    endcase
  endfunction : pick

  // Counts edges until an output reaches a level; a hang ends the run
  task automatic wl(input int s, input logic lvl, input int lim);
    n = 0;
    while (pick(s) !== lvl && n < lim) begin
      @(posedge clock_in);
      n++;
    end
    if (pick(s) !== lvl) begin
      n_errors++;
      $display("FAIL wait %0d expected %b seen timeout", s, lvl);
      end_sim();
    end
  endtask : wl

  // One classic cycle; the request holds until ack is sampled high
  task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel,
                    input logic [31:0] wd);
    int i;
    i = 0;
    @(posedge clock_in);
    {wb_cyc_in, wb_stb_in, wb_we_in} <= {2'b11, we};
    wb_adr_in <= adr;
    wb_sel_in <= sel;
    wb_dat_in <= wd;
    do begin
      @(posedge clock_in);
      i++;
    end while (wb_ack_out !== 1'b1 && i < 20);
    rd = wb_dat_out;
    {wb_cyc_in, wb_stb_in, wb_we_in} <= 3'b000;
    if (wb_ack_out !== 1'b1) begin
      n_errors++;
      $display("FAIL wb ack expected 1 seen timeout");
      end_sim();
    end
  endtask : wb

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock_in);
    rst_in <= 1'b0;
    chk("reset state", 3'b011, {switch_on_out, low_power_out, pg_pin});
    wb(1'b0, lsfs_pkg::CTRL_ADDR, 4'hf, 32'h0);
    chk("ctrl reset", 32'(lsfs_pkg::CTRL_RESET), rd);
    wb(1'b1, 4'hc, 4'hf, 32'hffffffff);
    wb(1'b0, 4'hc, 4'hf, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(1'b0, lsfs_pkg::STATUS_ADDR, 4'hf, 32'h0);
    chk("status off", 32'h0, rd);
    // Enable under lockout must not start; release starts the sequence
    input_undervoltage_lockout <= 1'b1;
    run <= 1'b1;
    repeat (3 * DEB) @(posedge clock_in);
    chk("input_undervoltage_lockout hold", 2'b01, {switch_on_out, low_power_out});
    input_undervoltage_lockout <= 1'b0;
    wl(0, 1'b1, 6 * DEB);
    rng("debounce", DEB, DEB + 6, n);
    chk("start", 3'b111, {switch_on_out, ramp_active_out, current_limit_out});
    wl(1, 1'b0, 4 * LIM);
    rng("ramp", RMP, RMP, n);
    wl(2, 1'b0, 4 * LIM);
    rng("limit", LIM - RMP, LIM - RMP, n);
    wl(4, 1'b1, 4 * LIM);
    rng("pg delay", PGD - 1, PGD + 1, n);
    chk("pg pin", 1'b0, pg_pin);
    wb(1'b0, lsfs_pkg::STATUS_ADDR, 4'hf, 32'h0);
    chk("status on", 9'h124, rd[8:0]);
    // Only the selected over-voltage comparator may trip
    flt <= 5'h02;
    repeat (10) @(posedge clock_in);
    chk("ext ignored", 1'b1, power_good_flag_n_oe_out);
    adj <= 1'b1;
    flt <= 5'h01;
    repeat (10) @(posedge clock_in);
    chk("int ignored", 1'b1, power_good_flag_n_oe_out);
    flt <= 5'h00;
    // Reverse current regulates without a fault, then recovers
    rev <= 1'b1;
    wl(3, 1'b1, 10);
    repeat (20) @(posedge clock_in);
    chk("rcp on", 2'b11, {switch_on_out, power_good_flag_n_oe_out});
    rev <= 1'b0;
    wl(3, 1'b0, 400);
    rng("rcp recovery", RCPR, RCPR + 6, n);
    chk("rcp no fault", 2'b11, {switch_on_out, power_good_flag_n_oe_out});
    // Every fault opens the switch and retries once cleared
    for (int k = 0; k < 5; k++) begin
      adj <= (k == 1);
      flt <= 5'h01 << k;
      cool <= (k != 4);
      wl(0, 1'b0, 8);
      rng("fault off", 0, 5, n);
      chk("fault pg", 1'b1, pg_pin);
      wb(1'b0, lsfs_pkg::STATUS_ADDR, 4'hf, 32'h0);
      chk("sticky", 1'b1, rd[12+sb[k]]);
      wb(1'b1, lsfs_pkg::STATUS_ADDR, 4'h2, 32'h00000f00);
      flt <= (k == 4) ? 5'h00 : flt;
      repeat (2 * DEB) @(posedge clock_in);
      if (k != 3) chk("held off", 1'b0, switch_on_out);
      flt <= 5'h00;
      cool <= 1'b1;
      wl(0, 1'b1, 6 * DEB);
      if (k != 3) rng("retry", DEB, DEB + 6, n);
      wl(4, 1'b1, 6 * DEB);
    end
    // With every fault gone a clear empties the fault record
    wb(1'b1, lsfs_pkg::STATUS_ADDR, 4'h2, 32'h00000f00);
    wb(1'b0, lsfs_pkg::STATUS_ADDR, 4'hf, 32'h0);
    chk("sticky clear", 32'h0, rd[15:12]);
    // Register disable forces off; clearing it restarts from debounce
    wb(1'b1, lsfs_pkg::CTRL_ADDR, 4'h1, 32'h1);
    wl(0, 1'b0, 8);
    wb(1'b0, lsfs_pkg::CTRL_ADDR, 4'hf, 32'h0);
    chk("ctrl", 32'h1, rd);
    wb(1'b1, lsfs_pkg::CTRL_ADDR, 4'h1, 32'h0);
    wl(0, 1'b1, 6 * DEB);
    rng("ctrl restart", DEB, DEB + 6, n);
    wl(4, 1'b1, 6 * DEB);
    // Lockout while on acts as a disable
    input_undervoltage_lockout <= 1'b1;
    wl(0, 1'b0, 8);
    repeat (2) @(posedge clock_in);
    chk("input_undervoltage_lockout off", 2'b11, {low_power_out, pg_pin});
    input_undervoltage_lockout <= 1'b0;
    wl(4, 1'b1, 6 * DEB);
    // Host disable turns off promptly and ends retries
    run <= 1'b0;
    wl(0, 1'b0, 40);
    rng("turn off", 0, 6, n);
    repeat (2) @(posedge clock_in);
    chk("disabled", 2'b11, {low_power_out, pg_pin});
    wb(1'b0, lsfs_pkg::RETRY_ADDR, 4'hf, 32'h0);
    chk("retry cleared", 32'h0, rd);
    // Output never ramps: short found at end of start, retried again
    near <= 1'b0;
    run <= 1'b1;
    wl(0, 1'b1, 6 * DEB);
    wl(0, 1'b0, 4 * LIM);
    rng("short start", LIM, LIM + 2, n);
    wl(0, 1'b1, 6 * DEB);
    rng("short retry", DEB, DEB + 6, n);
    wl(0, 1'b0, 4 * LIM);
    wb(1'b0, lsfs_pkg::STATUS_ADDR, 4'hf, 32'h0);
    chk("short sticky", 1'b1, rd[12+lsfs_pkg::F_SHORT]);
    // One failed first start plus one failed retry since enable
    wb(1'b0, lsfs_pkg::RETRY_ADDR, 4'hf, 32'h0);
    chk("retry count", 32'h2, rd);
    run <= 1'b0;
    end_sim();
  end
endmodule : lsfs_tb_top
`default_nettype wire
